// ==== rtl/cfg_port_pkg.sv ====
package cfg_port_pkg;
  localparam int          DATA_W      = 28;
  localparam int          ADDR_W      = 4;
  localparam int          FRAME_W     = 32;
  localparam int          NUM_REGS    = 12;
  localparam int          CNT_W       = 6;
  localparam int          IDX_W       = 5;
  localparam int          DIV_W       = 8;
  localparam int          NV_WAIT_W   = 32;
  localparam logic [3:0]  LAST_REG    = 4'hb;
  localparam logic [3:0]  READ_ADDR   = 4'he;
  localparam logic [3:0]  COPY_ADDR   = 4'hf;
  localparam logic [27:0] UNLOCK_DATA = 28'h0000000;
  localparam logic [27:0] LOCK_DATA   = 28'h0000001;
  localparam int          RSEL_LSB    = 4;
  localparam logic [27:0] NV_DEFAULT  = 28'h0000000;
  localparam logic [3:0]  RSP_ADDR    = 4'h0;
  localparam logic [5:0]  FRAME_BITS  = 6'h20;
  localparam logic [5:0]  CNT_FIRST   = 6'h01;
  localparam logic [5:0]  CNT_MAX     = 6'h3f;
  localparam logic [4:0]  IDX_FIRST   = 5'h01;
  // timing
  localparam int          MCLK_MHZ     = 100;
  localparam int          SCLK_HALF_NS = 40;
  localparam int          GAP_NS       = 160;
  localparam int          NV_WAIT_MS   = 50;
  localparam int          SCLK_HALF    = (SCLK_HALF_NS * MCLK_MHZ + 999) / 1000;
  localparam int          GAP_CYC      = (GAP_NS * MCLK_MHZ + 999) / 1000;
  localparam int          NV_WAIT_CYC  = NV_WAIT_MS * MCLK_MHZ * 1000;

  typedef enum logic [1:0] {
    CMD_WRITE  = 2'h0,
    CMD_READ   = 2'h1,
    CMD_UNLOCK = 2'h2,
    CMD_LOCK   = 2'h3
  } cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SHIFT = 4'h2,
    ST_GAP   = 4'h4,
    ST_WAIT  = 4'h8
  } state_t;
endpackage : cfg_port_pkg

// ==== rtl/cfg_port_if.sv ====
`timescale 1ns/100ps
interface cfg_port_if;
  logic sclk;
  logic mosi;
  logic miso;
  logic frame_strobe;

  modport dev  (input sclk, input mosi, input frame_strobe, output miso);
  modport host (output sclk, output mosi, output frame_strobe, input miso);
endinterface : cfg_port_if

// ==== rtl/cfg_sync.sv ====
`timescale 1ns/100ps
module cfg_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  input  wire logic rst_val,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= rst_val;
      q      <= rst_val;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : cfg_sync

// ==== rtl/cfg_port_device.sv ====
`timescale 1ns/100ps
module cfg_port_device (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic                   nv_init_b,
  cfg_port_if.dev                     link,
  output logic [12*28-1:0]            cfg_flat,
  output logic                        nv_locked,
  output logic                        frame_done
);
  logic [cfg_port_pkg::FRAME_W-1:0]  rx_q;
  logic [cfg_port_pkg::CNT_W-1:0]    cnt_q;
  logic                              start_q;
  logic [cfg_port_pkg::IDX_W-1:0]    idx_q;
  logic                              miso_q;
  logic [cfg_port_pkg::DATA_W-1:0]   regs_q [cfg_port_pkg::NUM_REGS];
  logic [cfg_port_pkg::DATA_W-1:0]   nv_q   [cfg_port_pkg::NUM_REGS];
  logic                              locked_q;
  logic [cfg_port_pkg::FRAME_W-1:0]  rd_word_q;
  logic                              le_s;
  logic                              le_d_q;
  logic                              done_q;

  // link side: start flag held set while strobe is high
  always_ff @(posedge link.sclk or posedge link.frame_strobe) begin
    if (link.frame_strobe) begin
      start_q <= 1'b1;
    end else begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (!link.frame_strobe) begin
      rx_q  <= {link.mosi, rx_q[cfg_port_pkg::FRAME_W-1:1]};
      cnt_q <= start_q ? cfg_port_pkg::CNT_FIRST
             : (cnt_q == cfg_port_pkg::CNT_MAX) ? cnt_q : cnt_q + 1'b1;
    end
  end

  // readback; bit 0 is the cleared level shown at strobe fall
  always_ff @(negedge link.sclk or posedge link.frame_strobe) begin
    if (link.frame_strobe) begin
      miso_q <= 1'b0;
      idx_q  <= cfg_port_pkg::IDX_FIRST;
    end else begin
      miso_q <= rd_word_q[idx_q];
      idx_q  <= idx_q + 1'b1;
    end
  end
  assign link.miso = miso_q;

  // core side; frame contents are static while strobe is high
  cfg_sync u_le_sync (
    .clk     (mclk),
    .rst_b   (rst_b),
    .d       (link.frame_strobe),
    .rst_val (1'b1),
    .q       (le_s)
  );

  wire                             le_rise  = le_s & ~le_d_q;
  wire                             good     = le_rise & (cnt_q == cfg_port_pkg::FRAME_BITS);
  wire [cfg_port_pkg::ADDR_W-1:0]  f_addr   = rx_q[cfg_port_pkg::FRAME_W-1:cfg_port_pkg::DATA_W];
  wire [cfg_port_pkg::DATA_W-1:0]  f_data   = rx_q[cfg_port_pkg::DATA_W-1:0];
  wire                             is_wr    = good & (f_addr <= cfg_port_pkg::LAST_REG);
  wire                             is_rd    = good & (f_addr == cfg_port_pkg::READ_ADDR);
  wire                             is_lock  = f_data == cfg_port_pkg::LOCK_DATA;
  wire                             is_unl   = f_data == cfg_port_pkg::UNLOCK_DATA;
  wire                             is_cp    = good & (f_addr == cfg_port_pkg::COPY_ADDR)
                                              & (is_lock | is_unl);
  wire [3:0]                       rsel     = f_data[cfg_port_pkg::RSEL_LSB+3:cfg_port_pkg::RSEL_LSB];
  wire                             rsel_ok  = rsel <= cfg_port_pkg::LAST_REG;
  wire [cfg_port_pkg::DATA_W-1:0]  rsel_dat = rsel_ok ? regs_q[rsel] : '0;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      le_d_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      le_d_q <= le_s;
      done_q <= le_rise;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      regs_q <= nv_q;
    end else if (is_wr) begin
      regs_q[f_addr] <= f_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nv_init_b) begin
      for (int i = 0; i < cfg_port_pkg::NUM_REGS; i++) begin
        nv_q[i] <= cfg_port_pkg::NV_DEFAULT;
      end
      locked_q <= 1'b0;
    end else if (is_cp && !locked_q) begin
      nv_q <= regs_q;
      if (is_lock) begin
        locked_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_word_q <= '0;
    end else if (is_rd) begin
      rd_word_q <= {cfg_port_pkg::RSP_ADDR, rsel_dat[cfg_port_pkg::DATA_W-1:1], 1'b0};
    end
  end

  for (genvar g = 0; g < cfg_port_pkg::NUM_REGS; g++) begin : g_flat
    assign cfg_flat[g*cfg_port_pkg::DATA_W +: cfg_port_pkg::DATA_W] = regs_q[g];
  end
  assign nv_locked  = locked_q;
  assign frame_done = done_q;
endmodule : cfg_port_device

// ==== rtl/cfg_port_host.sv ====
`timescale 1ns/100ps
module cfg_port_host #(
  parameter int NV_WAIT = cfg_port_pkg::NV_WAIT_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        req_valid,
  input  wire cfg_port_pkg::cmd_t          req_cmd,
  input  wire logic [3:0]                  req_addr,
  input  wire logic [27:0]                 req_data,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [27:0]                      rsp_data,
  cfg_port_if.host                         link
);
  cfg_port_pkg::state_t              st_q;
  logic [cfg_port_pkg::FRAME_W-1:0]  frame_q;
  logic [cfg_port_pkg::FRAME_W-1:0]  tx_q;
  logic [cfg_port_pkg::FRAME_W-1:0]  rx_q;
  logic [cfg_port_pkg::CNT_W-1:0]    bits_q;
  logic [cfg_port_pkg::DIV_W-1:0]    div_q;
  logic [cfg_port_pkg::NV_WAIT_W-1:0] wait_q;
  logic                              sclk_q;
  logic                              mosi_q;
  logic                              le_q;
  logic                              rd_q;
  logic                              second_q;
  logic                              cp_q;
  logic                              rsp_q;
  logic                              miso_s;

  cfg_sync u_miso_sync (
    .clk     (mclk),
    .rst_b   (rst_b),
    .d       (link.miso),
    .rst_val (1'b1),
    .q       (miso_s)
  );

  wire [27:0] rd_sel   = {20'h00000, req_addr, 4'h0};
  wire [31:0] wr_frame = {req_addr, req_data};
  wire [31:0] rd_frame = {cfg_port_pkg::READ_ADDR, rd_sel};
  wire [31:0] ul_frame = {cfg_port_pkg::COPY_ADDR, cfg_port_pkg::UNLOCK_DATA};
  wire [31:0] lk_frame = {cfg_port_pkg::COPY_ADDR, cfg_port_pkg::LOCK_DATA};
  wire [31:0] new_frame = (req_cmd == cfg_port_pkg::CMD_WRITE)  ? wr_frame
                        : (req_cmd == cfg_port_pkg::CMD_READ)   ? rd_frame
                        : (req_cmd == cfg_port_pkg::CMD_UNLOCK) ? ul_frame : lk_frame;
  wire        half_end = div_q == cfg_port_pkg::DIV_W'(cfg_port_pkg::SCLK_HALF - 1);
  wire        gap_end  = div_q == cfg_port_pkg::DIV_W'(cfg_port_pkg::GAP_CYC - 1);
  wire        all_bits = bits_q == cfg_port_pkg::FRAME_BITS;
  wire        take     = (st_q == cfg_port_pkg::ST_IDLE) & req_valid;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_q     <= cfg_port_pkg::ST_IDLE;
      frame_q  <= '0;
      tx_q     <= '0;
      rx_q     <= '0;
      bits_q   <= '0;
      div_q    <= '0;
      wait_q   <= '0;
      sclk_q   <= 1'b0;
      mosi_q   <= 1'b0;
      le_q     <= 1'b1;
      rd_q     <= 1'b0;
      second_q <= 1'b0;
      cp_q     <= 1'b0;
      rsp_q    <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      unique case (st_q)
        cfg_port_pkg::ST_IDLE: begin
          if (take) begin
            frame_q  <= new_frame;
            tx_q     <= new_frame;
            mosi_q   <= new_frame[0];
            le_q     <= 1'b0;
            bits_q   <= '0;
            div_q    <= '0;
            rd_q     <= req_cmd == cfg_port_pkg::CMD_READ;
            cp_q     <= req_cmd[1];
            second_q <= 1'b0;
            st_q     <= cfg_port_pkg::ST_SHIFT;
          end
        end
        cfg_port_pkg::ST_SHIFT: begin
          div_q <= half_end ? '0 : div_q + 1'b1;
          if (half_end && !sclk_q) begin
            if (all_bits) begin
              le_q <= 1'b1;
              st_q <= cfg_port_pkg::ST_GAP;
            end else begin
              sclk_q <= 1'b1;
              rx_q   <= {miso_s, rx_q[cfg_port_pkg::FRAME_W-1:1]};
              bits_q <= bits_q + 1'b1;
            end
          end else if (half_end) begin
            sclk_q <= 1'b0;
            tx_q   <= {1'b0, tx_q[cfg_port_pkg::FRAME_W-1:1]};
            mosi_q <= tx_q[1];
          end
        end
        cfg_port_pkg::ST_GAP: begin
          div_q <= gap_end ? '0 : div_q + 1'b1;
          if (gap_end) begin
            if (rd_q && !second_q) begin
              second_q <= 1'b1;
              tx_q     <= frame_q;
              mosi_q   <= frame_q[0];
              le_q     <= 1'b0;
              bits_q   <= '0;
              st_q     <= cfg_port_pkg::ST_SHIFT;
            end else if (cp_q) begin
              wait_q <= '0;
              st_q   <= cfg_port_pkg::ST_WAIT;
            end else begin
              rsp_q <= second_q;
              st_q  <= cfg_port_pkg::ST_IDLE;
            end
          end
        end
        cfg_port_pkg::ST_WAIT: begin
          wait_q <= wait_q + 1'b1;
          if (wait_q == cfg_port_pkg::NV_WAIT_W'(NV_WAIT - 1)) begin
            st_q <= cfg_port_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= cfg_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign req_ready         = st_q == cfg_port_pkg::ST_IDLE;
  assign rsp_valid         = rsp_q;
  assign rsp_data          = {rx_q[cfg_port_pkg::DATA_W-1:1], 1'b0};
  assign link.sclk         = sclk_q;
  assign link.mosi         = mosi_q;
  assign link.frame_strobe = le_q;
endmodule : cfg_port_host

// ==== verification/cfg_port_props.sv ====
`timescale 1ns/100ps
module cfg_port_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic frame_strobe
);
  logic       sclk_q;
  logic [5:0] rises_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // sclk rises counted within one frame
  always_ff @(posedge mclk) begin
    sclk_q <= sclk;
    if (frame_strobe) begin
      rises_q <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rises_q <= rises_q + 6'h01;
    end
  end
  property p_mosi_fall;
    $changed(mosi) && !frame_strobe |-> $fell(sclk) || $fell(frame_strobe);
  endproperty
  a_mosi_fall: assert property (p_mosi_fall) else $error("mosi moved off sclk fall");
  property p_miso_fall;
    $changed(miso) && !frame_strobe && !$past(frame_strobe) |-> $fell(sclk);
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved off sclk fall");
  property p_sclk_idle;
    frame_strobe && $past(frame_strobe) |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk runs outside frame");
  property p_miso_idle;
    frame_strobe |-> !miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven outside frame");
  property p_frame_len;
    $rose(frame_strobe) |-> rises_q == 6'h20;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 32 bits");
  property p_gap;
    $rose(frame_strobe) |-> frame_strobe [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("strobe gap too short");
  property p_first_rise;
    $fell(frame_strobe) |-> ##[1:8] $rose(sclk);
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("no sclk after frame start");
  property p_half;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_half: assert property (p_half) else $error("sclk high phase wrong");
endmodule : cfg_port_props

// ==== verification/serial_config_register_port_bench.sv ====
`timescale 1ns/100ps
module serial_config_register_port_bench;
  logic               mclk = 1'b0;
  logic               rst_b = 1'b0;
  logic               nv_init_b = 1'b0;
  logic               req_valid = 1'b0;
  cfg_port_pkg::cmd_t req_cmd = cfg_port_pkg::CMD_WRITE;
  logic [3:0]         req_addr = 4'h0;
  logic [27:0]        req_data = 28'h0000000;
  logic               req_ready;
  logic               rsp_valid;
  logic [27:0]        rsp_data;
  logic [12*28-1:0]   cfg_flat;
  logic               nv_locked;
  logic               frame_done;
  int                 num_errors = 0;
  int                 n_checks = 0;
  int                 n_frames = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (frame_done === 1'b1) n_frames <= n_frames + 1;
  end

  cfg_port_if link ();
  cfg_port_device i_cfg_port_device (.mclk(mclk), .rst_b(rst_b), .nv_init_b(nv_init_b),
    .link(link), .cfg_flat(cfg_flat), .nv_locked(nv_locked), .frame_done(frame_done));
  cfg_port_host #(.NV_WAIT(50)) i_cfg_port_host (.mclk(mclk), .rst_b(rst_b),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(link));
  cfg_port_props i_cfg_port_props (.mclk(mclk), .rst_b(rst_b), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso), .frame_strobe(link.frame_strobe));

  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [27:0] pat(input int g);
    return 28'h5a5a5a5 + 28'(g) * 28'h0123457;
  endfunction : pat

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // nv low also restores the factory nonvolatile state
  task automatic do_reset(input logic nv);
    @(posedge mclk);
    #1;
    rst_b = 1'b0;
    nv_init_b = nv;
    repeat (20) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    nv_init_b = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask : do_reset

  task automatic wait_ready;
    int i;
    for (i = 0; i < 3000 && req_ready !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    check(28'(req_ready), 28'h0000001);
  endtask : wait_ready

  task automatic req(input cfg_port_pkg::cmd_t c, input logic [3:0] a, input logic [27:0] d);
    wait_ready();
    req_cmd = c;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
  endtask : req

  task automatic settle;
    wait_ready();
    repeat (8) @(posedge mclk);
    #1;
  endtask : settle

  task automatic rd(input logic [3:0] r, input logic [27:0] exp);
    int i;
    req(cfg_port_pkg::CMD_READ, r, 28'h0000000);
    for (i = 0; i < 3000 && rsp_valid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    check(28'(rsp_valid), 28'h0000001);
    check(rsp_data, exp);
  endtask : rd

  initial begin : main
    int g;
    do_reset(1'b0);
    for (g = 0; g < 12; g++) check(cfg_flat[g*28 +: 28], 28'h0000000);
    check(28'(nv_locked), 28'h0000000);
    $display("test reset done");
    for (g = 0; g < 12; g++) req(cfg_port_pkg::CMD_WRITE, 4'(g), pat(g));
    req(cfg_port_pkg::CMD_WRITE, 4'hc, 28'hfffffff);
    settle();
    for (g = 0; g < 12; g++) check(cfg_flat[g*28 +: 28], pat(g));
    check(28'(n_frames), 28'h000000d);
    $display("test write done");
    for (g = 0; g < 13; g++) rd(4'(g), g < 12 ? pat(g) & 28'hffffffe : 28'h0000000);
    $display("test read done");
    req(cfg_port_pkg::CMD_UNLOCK, 4'h0, 28'h0000000);
    settle();
    check(28'(nv_locked), 28'h0000000);
    req(cfg_port_pkg::CMD_WRITE, 4'h0, 28'h1234567);
    settle();
    do_reset(1'b1);
    check(cfg_flat[27:0], pat(0));
    check(cfg_flat[5*28 +: 28], pat(5));
    req(cfg_port_pkg::CMD_LOCK, 4'h0, 28'h0000001);
    settle();
    check(28'(nv_locked), 28'h0000001);
    req(cfg_port_pkg::CMD_WRITE, 4'h0, 28'h7654321);
    settle();
    check(cfg_flat[27:0], 28'h7654321);
    req(cfg_port_pkg::CMD_UNLOCK, 4'h0, 28'h0000000);
    settle();
    do_reset(1'b1);
    check(cfg_flat[27:0], pat(0));
    check(28'(nv_locked), 28'h0000001);
    $display("test nonvolatile done");
    report_and_stop();
  end

  initial begin : watchdog
    #400_000;
    num_errors++;
    report_and_stop();
  end
endmodule : serial_config_register_port_bench
